// >>> logic/srcmb_pkg.sv
// Constants, register map and types shared by the system reset combiner.
package srcmb_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the low address bits).
  localparam logic [15:0] NMI_CTRL_OFS = 16'h1200;
  localparam logic [15:0] CAUSE_OFS    = 16'h1260;
  localparam logic [15:0] SWTRIG_OFS   = 16'h1270;
  localparam logic [15:0] IRQ_STAT_OFS = 16'h1280;
  localparam logic [15:0] IRQ_CLR_OFS  = 16'h1284;
  localparam logic [15:0] IRQ_EN_OFS   = 16'h1288;

  // Alias selector taken from address bits 3:2.
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR   = 2'h1;
  localparam logic [1:0] ALIAS_SET   = 2'h2;
  localparam logic [1:0] ALIAS_INV   = 2'h3;

  // ==========================================================================
  // Reset cause flag positions.
  localparam int CAUSE_POR  = 0;
  localparam int CAUSE_BOR  = 1;
  localparam int CAUSE_WDTO = 4;
  localparam int CAUSE_DMTO = 5;
  localparam int CAUSE_SWR  = 6;
  localparam int CAUSE_EXTR = 7;
  localparam int CAUSE_CMR  = 9;

  localparam logic [31:0] CAUSE_IMPL_MASK = 32'hCF03_06FF;
  // Flags without a dedicated source input are set through the auxiliary vector.
  localparam logic [31:0] CAUSE_AUX_MASK  = 32'hCF03_040C;

  // Software trigger bit and NMI register layout.
  localparam int          SWTRIG_BIT     = 0;
  localparam logic [31:0] NMI_IMPL_MASK  = 32'h038F_FFFF;
  localparam logic [31:0] NMI_FLAG_MASK  = 32'h038F_0000;
  localparam logic [31:0] NMI_HW_MASK    = 32'h0307_0000;
  localparam logic [31:0] REG_RESET_VAL  = 32'h0000_0000;

  // ==========================================================================
  // Interrupt event positions, one per reset source.
  localparam int IRQ_W     = 8;
  localparam int IRQ_POR   = 0;
  localparam int IRQ_BOR   = 1;
  localparam int IRQ_ZERO_POWER_BROWNOUT = 2;
  localparam int IRQ_EXT   = 3;
  localparam int IRQ_SWR   = 4;
  localparam int IRQ_WDT   = 5;
  localparam int IRQ_DMT   = 6;
  localparam int IRQ_CMR   = 7;

  // ==========================================================================
  // Least width of the released reset pulse tail, rounded up to clock cycles.
  localparam int RST_HOLD_NS   = 200;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ACTIVE,
    ST_HOLD
  } srcmb_rst_state_t;

endpackage : srcmb_pkg

// >>> logic/srcmb_reset_stretch.sv
// Reset stretcher that holds the system reset and releases it on the clock.
`timescale 1ns/1ps
`default_nettype none
module srcmb_reset_stretch #(
  parameter int HOLD_CYC = srcmb_pkg::RST_HOLD_CYC
) (
  input  wire logic clk,       // System clock.
  input  wire logic rst_n,     // Synchronous reset, active low.
  input  wire logic resetReq,  // Any reset source active.
  output logic      resetOut   // Registered system reset, active high.
);

  localparam int CW = $clog2(HOLD_CYC + 1);

  srcmb_pkg::srcmb_rst_state_t state_q;
  logic [CW-1:0]               cnt_q;

  // ==========================================================================
  // Reset stays high while any source is active, then for HOLD_CYC more cycles.
  // The release comes from a flip-flop, so downstream logic sees a clean edge.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q  <= srcmb_pkg::ST_ACTIVE;
      cnt_q    <= '0;
      resetOut <= 1'b1;
    end
    else
    begin
      case (state_q)
        srcmb_pkg::ST_RUN:
        begin
          if (resetReq)
          begin
            state_q  <= srcmb_pkg::ST_ACTIVE;
            resetOut <= 1'b1;
          end
        end
        srcmb_pkg::ST_ACTIVE:
        begin
          if (!resetReq)
          begin
            state_q <= srcmb_pkg::ST_HOLD;
            cnt_q   <= CW'(HOLD_CYC - 1);
          end
        end
        srcmb_pkg::ST_HOLD:
        begin
          if (resetReq)
            state_q <= srcmb_pkg::ST_ACTIVE;
          else if (cnt_q == '0)
          begin
            state_q  <= srcmb_pkg::ST_RUN;
            resetOut <= 1'b0;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default:
        begin
          state_q  <= srcmb_pkg::ST_ACTIVE;
          resetOut <= 1'b1;
        end
      endcase
    end
  end

endmodule : srcmb_reset_stretch
`default_nettype wire

// >>> logic/system_reset_combiner.sv
// Reset combiner: reset sources, cause flags, trigger, NMI register and APB slave.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module system_reset_combiner #(
  parameter int HOLD_CYC = srcmb_pkg::RST_HOLD_CYC
) (
  input  wire logic        clk,                 // System clock, 25 MHz.
  input  wire logic        rst_n,               // Synchronous reset, active low.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB access phase.
  input  wire logic        pwrite,              // APB write when high.
  input  wire logic [15:0] paddr,               // APB byte address, low bits.
  input  wire logic [31:0] pwdata,              // APB write data.
  output logic      [31:0] prdata,              // APB read data, registered.
  output logic             pready,              // APB ready, always high.
  output logic             pslverr,             // APB error on unmapped address.
  input  wire logic        porDetect,           // Power-on event, high active.
  input  wire logic        brownoutReset,       // Brown-out event.
  input  wire logic        zeroPowerBrownout,   // Zero-power brown-out event.
  input  wire logic        externalClearPin_n,  // External clear pin, low active.
  input  wire logic        watchdogResetSource, // Watchdog time-out.
  input  wire logic        deadmanResetSource,  // Deadman time-out.
  input  wire logic        configMismatchReset, // Configuration mismatch.
  input  wire logic [31:0] auxCauseSet,         // Set strobes for other cause flags.
  input  wire logic [31:0] nmiCauseSet,         // Set strobes for NMI flags.
  output logic             systemResetOut,      // System reset, active high.
  output logic             nmiOut,              // NMI request, registered level.
  output logic             irqOut               // Interrupt, registered level.
);

  // ==========================================================================
  // Helpers shared by the decoder and the alias write path.
  function automatic logic hitBase(input logic [15:0] a, input logic [15:0] ofs);
    hitBase = ({a[15:4], 4'h0} == ofs);
  endfunction : hitBase

  function automatic logic [31:0] applyWrite(input logic [31:0] cur,
                                             input logic [31:0] wd,
                                             input logic [1:0]  al);
    case (al)
      srcmb_pkg::ALIAS_CLR: applyWrite = cur & ~wd;
      srcmb_pkg::ALIAS_SET: applyWrite = cur | wd;
      srcmb_pkg::ALIAS_INV: applyWrite = cur ^ wd;
      default:              applyWrite = wd;
    endcase
  endfunction : applyWrite

  logic [31:0]               cause_q, cause_d;
  logic [31:0]               nmi_q, nmi_d;
  logic                      swArm_q, swArm_d;
  logic [srcmb_pkg::IRQ_W-1:0] irqStat_q, irqStat_d;
  logic [srcmb_pkg::IRQ_W-1:0] irqEn_q, irqEn_d;
  logic [31:0]               prdata_d;

  // ==========================================================================
  // Address decode. Aliases share one base; interrupt registers are exact words.
  wire [1:0]  alias_    = paddr[3:2];
  wire [15:0] wordAddr  = {paddr[15:2], 2'b00};
  wire        hitCause  = hitBase(paddr, srcmb_pkg::CAUSE_OFS);
  wire        hitSwTrig = hitBase(paddr, srcmb_pkg::SWTRIG_OFS);
  wire        hitNmi    = hitBase(paddr, srcmb_pkg::NMI_CTRL_OFS);
  wire        hitIStat  = (wordAddr == srcmb_pkg::IRQ_STAT_OFS);
  wire        hitIClr   = (wordAddr == srcmb_pkg::IRQ_CLR_OFS);
  wire        hitIEn    = (wordAddr == srcmb_pkg::IRQ_EN_OFS);
  wire        hitAny    = hitCause | hitSwTrig | hitNmi | hitIStat | hitIClr | hitIEn;
  wire        setupRd   = psel & ~penable & ~pwrite;
  wire        wrEn      = psel & penable & pwrite & hitAny;

  // Zero wait states; an unmapped access completes with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  // ==========================================================================
  // Source gathering. Every source feeds one request line.
  // There is no per-source enable: a source that is stuck active keeps the
  // device in reset, which is the safe side for a supervisor that fails.
  wire extClear = ~externalClearPin_n;
  wire resetReq = porDetect | brownoutReset | zeroPowerBrownout
                | extClear | swArm_q
                | watchdogResetSource | deadmanResetSource
                | configMismatchReset;

  // Hardware set strobes for the cause flags; the zero-power brown-out
  // shares the brown-out flag since it has no flag of its own.
  wire [31:0] hwCauseSet =
      (32'(porDetect) << srcmb_pkg::CAUSE_POR)
    | (32'(brownoutReset | zeroPowerBrownout) << srcmb_pkg::CAUSE_BOR)
    | (32'(watchdogResetSource) << srcmb_pkg::CAUSE_WDTO)
    | (32'(deadmanResetSource) << srcmb_pkg::CAUSE_DMTO)
    | (32'(swArm_q) << srcmb_pkg::CAUSE_SWR)
    | (32'(extClear) << srcmb_pkg::CAUSE_EXTR)
    | (32'(configMismatchReset) << srcmb_pkg::CAUSE_CMR)
    | (auxCauseSet & srcmb_pkg::CAUSE_AUX_MASK);

  // ==========================================================================
  // Cause flags: software writes through any alias, but a hardware set in
  // the same cycle wins so that no event is lost. A software set only
  // stores the flag; it never reaches the reset request.
  wire [31:0] causeSw = (wrEn & hitCause) ? applyWrite(cause_q, pwdata, alias_) : cause_q;
  assign cause_d = (causeSw | hwCauseSet) & srcmb_pkg::CAUSE_IMPL_MASK;

  // Trigger: a write that leaves bit 0 at one arms a reset for one cycle,
  // then hardware clears it. Reading the trigger always returns zero.
  wire [31:0] swTrigWr = applyWrite(srcmb_pkg::REG_RESET_VAL, pwdata, alias_);
  assign swArm_d = wrEn & hitSwTrig & swTrigWr[srcmb_pkg::SWTRIG_BIT];

  // NMI register: count and software NMI bits are plain storage; the
  // hardware flag bits also take set strobes with priority over software.
  wire [31:0] nmiSw = (wrEn & hitNmi) ? applyWrite(nmi_q, pwdata, alias_) : nmi_q;
  assign nmi_d = (nmiSw | (nmiCauseSet & srcmb_pkg::NMI_HW_MASK))
               & srcmb_pkg::NMI_IMPL_MASK;

  // ==========================================================================
  // Interrupt status: one sticky bit per source, cleared by write-one.
  wire [srcmb_pkg::IRQ_W-1:0] irqEvt = {configMismatchReset, deadmanResetSource,
                                        watchdogResetSource, swArm_q, extClear,
                                        zeroPowerBrownout, brownoutReset, porDetect};
  wire [srcmb_pkg::IRQ_W-1:0] irqClr = (wrEn & hitIClr) ? pwdata[srcmb_pkg::IRQ_W-1:0] : '0;
  assign irqStat_d = (irqStat_q & ~irqClr) | irqEvt;
  assign irqEn_d   = (wrEn & hitIEn) ? pwdata[srcmb_pkg::IRQ_W-1:0] : irqEn_q;

  // ==========================================================================
  // Read mux, sampled in the setup phase so data is stable in the access phase.
  // Write-only words read as zero, and so do unimplemented bits.
  always_comb
  begin
    prdata_d = prdata;
    if (setupRd)
    begin
      prdata_d = srcmb_pkg::REG_RESET_VAL;
      if (hitCause)
        prdata_d = cause_q;
      else if (hitNmi)
        prdata_d = nmi_q;
      else if (hitIStat)
        prdata_d = 32'(irqStat_q);
      else if (hitIEn)
        prdata_d = 32'(irqEn_q);
    end
  end

  // ==========================================================================
  // State registers. Only the block reset clears them; the system reset it
  // produces does not, so software can read the cause after the reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cause_q   <= srcmb_pkg::REG_RESET_VAL;
      nmi_q     <= srcmb_pkg::REG_RESET_VAL;
      swArm_q   <= 1'b0;
      irqStat_q <= '0;
      irqEn_q   <= '0;
      prdata    <= '0;
      nmiOut    <= 1'b0;
      irqOut    <= 1'b0;
    end
    else
    begin
      cause_q   <= cause_d;
      nmi_q     <= nmi_d;
      swArm_q   <= swArm_d;
      irqStat_q <= irqStat_d;
      irqEn_q   <= irqEn_d;
      prdata    <= prdata_d;
      nmiOut    <= |(nmi_d & srcmb_pkg::NMI_FLAG_MASK);
      irqOut    <= |(irqStat_d & irqEn_d);
    end
  end

  // ==========================================================================
  // Stretcher turns the combined request into the registered system reset.
  srcmb_reset_stretch #(
    .HOLD_CYC (HOLD_CYC)
  ) u_stretch (
    .clk      (clk),
    .rst_n    (rst_n),
    .resetReq (resetReq),
    .resetOut (systemResetOut)
  );

  // ==========================================================================
  // Checks on the reset path and register behaviour.
  chk_rise_has_cause: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(systemResetOut) |-> $past(resetReq))
    else $error("System reset rose without any source.");

  chk_power_sources: assert property (
    @(posedge clk) disable iff (!rst_n)
    (porDetect || brownoutReset || zeroPowerBrownout) |=> systemResetOut)
    else $error("Power source did not assert system reset.");

  chk_pin_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    !externalClearPin_n |=> systemResetOut && cause_q[srcmb_pkg::CAUSE_EXTR])
    else $error("Clear pin did not reset or flag.");

  chk_timer_reset: assert property (
    @(posedge clk) disable iff (!rst_n)
    (watchdogResetSource || deadmanResetSource) |=> systemResetOut)
    else $error("Timer time-out did not assert system reset.");

  chk_mismatch_cause: assert property (
    @(posedge clk) disable iff (!rst_n)
    configMismatchReset |=> systemResetOut && cause_q[srcmb_pkg::CAUSE_CMR])
    else $error("Mismatch did not reset or set its own flag.");

  chk_clear_alias: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrEn && hitCause && alias_ == srcmb_pkg::ALIAS_CLR && hwCauseSet == 32'h0)
      |=> cause_q == ($past(cause_q) & ~$past(pwdata)))
    else $error("Clear alias did not clear the written bits.");

  chk_unimpl_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((cause_q & ~srcmb_pkg::CAUSE_IMPL_MASK) == 32'h0)
      && ((nmi_q & ~srcmb_pkg::NMI_IMPL_MASK) == 32'h0))
    else $error("Unimplemented bit holds a one.");

  chk_reset_values: assert property (
    @(posedge clk)
    !rst_n |=> (cause_q == 32'h0) && (nmi_q == 32'h0) && !swArm_q)
    else $error("Register not zero after block reset.");

  chk_flag_set_wins: assert property (
    @(posedge clk) disable iff (!rst_n)
    porDetect |=> cause_q[srcmb_pkg::CAUSE_POR])
    else $error("Power-on flag lost.");

  chk_trigger_selfclr: assert property (
    @(posedge clk) disable iff (!rst_n)
    swArm_q |=> !swArm_q ##0 systemResetOut ##0 cause_q[srcmb_pkg::CAUSE_SWR])
    else $error("Trigger not self-cleared or reset not issued.");

  chk_hold_active: assert property (
    @(posedge clk) disable iff (!rst_n)
    resetReq [*2] |-> systemResetOut)
    else $error("System reset released while a source is active.");

  // ==========================================================================
  // Checks on the alias paths, the interrupt and NMI levels and the bus.
  // They watch the internal decode, so a broken alias shows up at the write
  // itself rather than several transfers later in a read-back.
  // The interrupt and NMI levels are compared with the stored words.
  chk_set_alias: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrEn && hitCause && alias_ == srcmb_pkg::ALIAS_SET)
      |=> ((cause_q & $past(pwdata) & srcmb_pkg::CAUSE_IMPL_MASK)
          == ($past(pwdata) & srcmb_pkg::CAUSE_IMPL_MASK)))
    else $error("Set alias did not set the written bits.");

  chk_invert_alias: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrEn && hitCause && alias_ == srcmb_pkg::ALIAS_INV && hwCauseSet == 32'h0)
      |=> cause_q == (($past(cause_q) ^ $past(pwdata)) & srcmb_pkg::CAUSE_IMPL_MASK))
    else $error("Invert alias did not toggle the written bits.");

  chk_trigger_reads_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (setupRd && hitSwTrig) |=> prdata == 32'h0)
    else $error("Trigger word read back non-zero.");

  chk_trigger_clr_alias: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrEn && hitSwTrig && alias_ == srcmb_pkg::ALIAS_CLR) |=> !swArm_q)
    else $error("Clear alias armed a software reset.");

  chk_zero_power_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    zeroPowerBrownout |=> systemResetOut && cause_q[srcmb_pkg::CAUSE_BOR])
    else $error("Zero-power brown-out did not reset or flag.");

  chk_set_beats_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wrEn && hitCause && alias_ == srcmb_pkg::ALIAS_CLR && watchdogResetSource)
      |=> cause_q[srcmb_pkg::CAUSE_WDTO])
    else $error("Software clear beat a watchdog flag set.");

  chk_unmapped_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psel && penable && pwrite && !hitAny && hwCauseSet == 32'h0)
      |=> $stable(cause_q))
    else $error("Unmapped write changed the cause flags.");

  chk_irq_event_sticks: assert property (
    @(posedge clk) disable iff (!rst_n)
    (irqEvt != '0) |=> ((irqStat_q & $past(irqEvt)) == $past(irqEvt)))
    else $error("Interrupt event did not set its status bit.");

  chk_irq_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    irqOut == |(irqStat_q & irqEn_q))
    else $error("Interrupt output disagrees with enabled status.");

  chk_nmi_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    nmiOut == |(nmi_q & srcmb_pkg::NMI_FLAG_MASK))
    else $error("NMI output disagrees with the NMI flags.");

  chk_read_data_stable: assert property (
    @(posedge clk) disable iff (!rst_n)
    (psel && penable && !pwrite) |=> $stable(prdata))
    else $error("Read data moved during the access phase.");

endmodule : system_reset_combiner
`default_nettype wire

// >>> verif/srcmb_source_model.sv
// Behavioural model of the reset sources and event strobes facing the combiner.
`timescale 1ns/1ps
`default_nettype none
module srcmb_source_model (
  input  wire logic        clk,                 // System clock.
  output logic             porDetect,           // Power-on event.
  output logic             brownoutReset,       // Brown-out event.
  output logic             zeroPowerBrownout,   // Zero-power brown-out event.
  output logic             externalClearPin_n,  // External clear pin, low active.
  output logic             watchdogResetSource, // Watchdog time-out.
  output logic             deadmanResetSource,  // Deadman time-out.
  output logic             configMismatchReset, // Configuration mismatch.
  output var logic  [31:0] auxCauseSet,         // Strobes for other cause flags.
  output var logic  [31:0] nmiCauseSet          // Strobes for NMI flags.
);
  // ==========================================================================
  // Source levels, indexed like the interrupt event positions.
  logic [7:0] lvl = 8'h00;

  // Every source idles inactive; the clear pin is low active on its wire.
  assign porDetect           = lvl[0];
  assign brownoutReset       = lvl[1];
  assign zeroPowerBrownout   = lvl[2];
  assign externalClearPin_n  = ~lvl[3];
  assign watchdogResetSource = lvl[5];
  assign deadmanResetSource  = lvl[6];
  assign configMismatchReset = lvl[7];

  // Strobes rest at zero between events.
  initial
  begin
    auxCauseSet = 32'h0000_0000;
    nmiCauseSet = 32'h0000_0000;
  end

  // Holds one source active for len edges, then drops it.
  task automatic fire(input int idx, input int len);
    @(posedge clk);
    lvl[idx] <= 1'b1;
    repeat (len) @(posedge clk);
    lvl[idx] <= 1'b0;
  endtask : fire

  // One-cycle strobe on the auxiliary and NMI set vectors.
  task automatic strobe(input logic [31:0] aux, input logic [31:0] nmi);
    @(posedge clk);
    auxCauseSet <= aux;
    nmiCauseSet <= nmi;
    @(posedge clk);
    auxCauseSet <= 32'h0000_0000;
    nmiCauseSet <= 32'h0000_0000;
  endtask : strobe
endmodule : srcmb_source_model
`default_nettype wire

// >>> verif/srcmb_testbench.sv
// Self-checking testbench for the system reset combiner.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================================
  // Signals. A short hold keeps the run brief.
  localparam int HOLD    = 2;
  localparam int CB[8]   = '{0, 1, 1, 7, 6, 4, 5, 9};
  localparam logic [15:0] CS = srcmb_pkg::CAUSE_OFS;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, auxCauseSet, nmiCauseSet, rd;
  logic        pready, pslverr, porDetect, brownoutReset, zeroPowerBrownout, err;
  logic        externalClearPin_n, watchdogResetSource, deadmanResetSource;
  logic        configMismatchReset, systemResetOut, nmiOut, irqOut;
  int          mismatches = 0;
  int          checked    = 0;

  system_reset_combiner #(.HOLD_CYC(HOLD)) DUT (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .porDetect(porDetect), .brownoutReset(brownoutReset),
    .zeroPowerBrownout(zeroPowerBrownout), .externalClearPin_n(externalClearPin_n),
    .watchdogResetSource(watchdogResetSource), .deadmanResetSource(deadmanResetSource),
    .configMismatchReset(configMismatchReset), .auxCauseSet(auxCauseSet),
    .nmiCauseSet(nmiCauseSet), .systemResetOut(systemResetOut), .nmiOut(nmiOut),
    .irqOut(irqOut)
  );
  srcmb_source_model src (
    .clk(clk), .porDetect(porDetect), .brownoutReset(brownoutReset),
    .zeroPowerBrownout(zeroPowerBrownout), .externalClearPin_n(externalClearPin_n),
    .watchdogResetSource(watchdogResetSource), .deadmanResetSource(deadmanResetSource),
    .configMismatchReset(configMismatchReset), .auxCauseSet(auxCauseSet),
    .nmiCauseSet(nmiCauseSet)
  );

  // The clock runs free at 25 MHz.
  initial
  begin
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Verdict, comparison and bus tasks.
  task automatic report_and_stop;
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // A hang counts as a mismatch and closes the run.
  task automatic hang;
    mismatches++;
    report_and_stop();
  endtask : hang

  // One transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) hang();
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rdc

  // Waits, bounded, for the system reset to reach a level.
  task automatic waitRst(input logic v);
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (systemResetOut === v) break;
    end
    if (n == 200) hang();
  endtask : waitRst

  // ==========================================================================
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    waitRst(1'b0);
    rdc(srcmb_pkg::NMI_CTRL_OFS, 32'h0);
    rdc(CS, 32'h0);
    rdc(srcmb_pkg::SWTRIG_OFS, 32'h0);
    // Every hardware source resets, flags its cause and raises its event.
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4) continue;
      wr(srcmb_pkg::IRQ_EN_OFS, 32'h1 << i);
      src.fire(i, 3);
      chk({31'h0, systemResetOut}, 32'h1);
      chk({31'h0, irqOut}, 32'h1);
      waitRst(1'b0);
      rdc(CS, 32'h1 << CB[i]);
      rdc(srcmb_pkg::IRQ_STAT_OFS, 32'h1 << i);
      wr(CS + 16'h0004, 32'hFFFF_FFFF);
      wr(srcmb_pkg::IRQ_CLR_OFS, 32'hFFFF_FFFF);
      rdc(CS, 32'h0);
      chk({31'h0, irqOut}, 32'h0);
    end
    // A clear that meets an active watchdog loses: the flag stays set.
    fork
      src.fire(5, 12);
      begin
        repeat (2) @(posedge clk);
        wr(CS + 16'h0004, 32'hFFFF_FFFF);
      end
    join
    waitRst(1'b0);
    rdc(CS, 32'h10);
    wr(CS + 16'h0004, 32'hFFFF_FFFF);
    wr(srcmb_pkg::IRQ_CLR_OFS, 32'hFFFF_FFFF);
    // Software trigger, plain then through its set alias, with masking.
    wr(srcmb_pkg::IRQ_EN_OFS, 32'h10);
    wr(srcmb_pkg::SWTRIG_OFS, 32'h1);
    waitRst(1'b1);
    rdc(srcmb_pkg::SWTRIG_OFS, 32'h0);
    waitRst(1'b0);
    rdc(CS, 32'h40);
    chk({31'h0, irqOut}, 32'h1);
    // The level follows an enable write on the write edge itself; the check samples it one edge later.
    wr(srcmb_pkg::IRQ_EN_OFS, 32'h0);
    @(posedge clk);
    chk({31'h0, irqOut}, 32'h0);
    wr(srcmb_pkg::IRQ_EN_OFS, 32'h10);
    @(posedge clk);
    chk({31'h0, irqOut}, 32'h1);
    wr(srcmb_pkg::IRQ_CLR_OFS, 32'h10);
    wr(srcmb_pkg::SWTRIG_OFS + 16'h0008, 32'h1);
    waitRst(1'b1);
    waitRst(1'b0);
    wr(CS + 16'h0004, 32'hFFFF_FFFF);
    // A one through the trigger's clear alias must not arm a reset.
    wr(srcmb_pkg::SWTRIG_OFS + 16'h0004, 32'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, systemResetOut}, 32'h0);
    // A software set stores flags without a reset; unimplemented bits stay zero.
    wr(CS, 32'hFFFF_FFFF);
    rdc(CS, srcmb_pkg::CAUSE_IMPL_MASK);
    repeat (4) @(posedge clk);
    chk({31'h0, systemResetOut}, 32'h0);
    wr(CS + 16'h000C, 32'h0000_0F00);
    rdc(CS, 32'hCF03_00FF);
    wr(CS + 16'h0004, 32'hFFFF_FFFF);
    wr(CS + 16'h0008, 32'h200);
    rdc(CS, 32'h200);
    wr(CS + 16'h0004, 32'hFFFF_FFFF);
    // NMI register storage and hardware-set flags.
    wr(srcmb_pkg::NMI_CTRL_OFS, 32'hFFFF_FFFF);
    rdc(srcmb_pkg::NMI_CTRL_OFS, srcmb_pkg::NMI_IMPL_MASK);
    chk({31'h0, nmiOut}, 32'h1);
    wr(srcmb_pkg::NMI_CTRL_OFS + 16'h0004, 32'hFFFF_FFFF);
    rdc(srcmb_pkg::NMI_CTRL_OFS, 32'h0);
    chk({31'h0, nmiOut}, 32'h0);
    src.strobe(32'h8000_0000, 32'h0100_0000);
    rdc(CS, 32'h8000_0000);
    rdc(srcmb_pkg::NMI_CTRL_OFS, 32'h0100_0000);
    chk({31'h0, nmiOut}, 32'h1);
    // An unmapped address answers with an error and zero data.
    apb(1'b0, 16'h1300, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wr(16'h1300, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    rdc(CS, 32'h8000_0000);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
